//--- src/tpc_pkg.sv
// Constants and types shared by the teleprinter line logic
package tpc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ     = 25000;
  localparam int PULSE_US    = 9091;
  localparam int PULSE_CYC   = (PULSE_US * CLK_KHZ) / 1000;
  localparam int BRK_MIN_MS  = 150;
  localparam int BRK_MIN_CYC = BRK_MIN_MS * CLK_KHZ;
  localparam int BRK_MAX_MS  = 400;
  localparam int BRK_MAX_CYC = BRK_MAX_MS * CLK_KHZ;
  localparam int CNT_W       = 24;

  // ----------------------------------------------------------------
  // Code layout
  // ----------------------------------------------------------------
  localparam int KEY_W     = 7;
  localparam int CODE_W    = 8;
  localparam int P5_POS    = 4;
  localparam int P7_POS    = 6;
  localparam int FRAME_LEN = 11;
  localparam int IDX_W     = 4;
  localparam logic MARK    = 1'b1;
  localparam logic SPACE   = 1'b0;
  localparam logic [1:0] STOP_PAIR = 2'h3;

  // ----------------------------------------------------------------
  // Pin synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYNC_W  = 4;
  localparam int SY_RX   = 0;
  localparam int SY_CONN = 1;
  localparam int SY_COPY = 2;
  localparam int SY_REL  = 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h1;

  // ----------------------------------------------------------------
  // Answer-back store (pattern value is arbitrary)
  // ----------------------------------------------------------------
  localparam int ANS_LEN_DEF = 4;
  localparam logic [ANS_LEN_DEF*CODE_W-1:0] ANS_ROM_DEF = 32'h8d8a_c1c2;

  typedef enum logic {TX_IDLE, TX_SEND} tpc_tx_state_t;

endpackage

//--- src/tpc_char_if.sv
// Keyboard character path between line logic and code former
`timescale 1ns/1ns
interface tpc_char_if;
  import tpc_pkg::*;
  logic [KEY_W-1:0]  key_code;
  logic              shift;
  logic              ctrl;
  logic              parity_kbd;
  logic [CODE_W-1:0] code8;
  modport enc  (input key_code, shift, ctrl, parity_kbd, output code8);
  modport user (output key_code, shift, ctrl, parity_kbd, input code8);
endinterface

//--- src/tpc_encode.sv
// Keyboard code former: shift, control and pulse 8 handling
`timescale 1ns/1ns
module tpc_encode
  import tpc_pkg::*;
(
  tpc_char_if.enc ch
);
  logic [KEY_W-1:0] mod_code;
  logic             base_p8;
  logic             p8;

  always_comb begin
    mod_code = ch.key_code;
    if (ch.shift) begin
      mod_code[P5_POS] = ~ch.key_code[P5_POS];
    end
    if (ch.ctrl) begin
      mod_code[P7_POS] = SPACE;
    end
    base_p8 = ch.parity_kbd ? ^ch.key_code : MARK;
    if (!ch.parity_kbd) begin
      p8 = MARK;
    end else if (ch.shift && ch.ctrl) begin
      p8 = base_p8;
    end else begin
      p8 = ^mod_code;
    end
    ch.code8 = {p8, mod_code};
  end
endmodule

//--- src/tpc_line.sv
// Teleprinter send distributor, break reception and receive selector hold
//
// Overview of operation
// - Received break sets latch, blocks transmission.
// - Latch holds until break release button pressed.
// - Copy disabled holds receive selector marking.
// - Distributor sends pulses: closed marks, open spaces.
// - Answer-back pulses come from stored pattern.
// - Reader pulse marks only where hole sensed.
// - Keyboard pulses 1,2,3,4,6 follow key code.
// - Shift inverts pulse 5.
// - Control forces pulse 7 spacing.
// - Nonparity keyboard: pulse 8 always marking.
// - Parity keyboard: pulse 8 makes marks even.
// - Parity recomputed after shift or control.
// - Shift plus control leaves pulse 8 unmodified.
// - Half duplex: send loop drives own selector.
`timescale 1ns/1ns
module tpc_line
  import tpc_pkg::*;
#(
  parameter int                          ANS_LEN = ANS_LEN_DEF,
  parameter logic [ANS_LEN*CODE_W-1:0]   ANS_ROM = ANS_ROM_DEF,
  parameter logic [CNT_W-1:0]            PULSE_N = CNT_W'(PULSE_CYC),
  parameter logic [CNT_W-1:0]            BRK_MIN = CNT_W'(BRK_MIN_CYC),
  parameter logic [CNT_W-1:0]            BRK_MAX = CNT_W'(BRK_MAX_CYC)
)(
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               reset_n_i,
  // Line and station pins
  input  wire logic               rx_line_i,
  input  wire logic               line_connected_i,
  input  wire logic               copy_enable_i,
  input  wire logic               break_release_button_i,
  // Station configuration
  input  wire logic               half_duplex_i,
  input  wire logic               parity_kbd_i,
  // Keyboard
  input  wire logic               key_req_i,
  input  wire logic [KEY_W-1:0]   key_code_i,
  input  wire logic               shift_i,
  input  wire logic               ctrl_i,
  // Tape reader and answer-back
  input  wire logic               reader_req_i,
  input  wire logic [CODE_W-1:0]  reader_holes_i,
  input  wire logic               ab_req_i,
  // Outputs
  output logic                    tx_line_o,
  output logic                    selector_o,
  output logic                    receive_break_latch_o,
  output logic                    ready_o,
  output logic                    key_taken_o,
  output logic                    reader_taken_o
);

  localparam int AB_W = $clog2(ANS_LEN + 1);

  typedef struct packed {
    tpc_tx_state_t        state;
    logic [SYNC_W-1:0]    s1;
    logic [SYNC_W-1:0]    s2;
    logic [SYNC_W-1:0]    s3;
    logic [SYNC_W-1:0]    filt;
    logic [CNT_W-1:0]     bit_cnt;
    logic [CNT_W-1:0]     space_cnt;
    logic [IDX_W-1:0]     pulse_idx;
    logic [FRAME_LEN-1:0] shreg;
    logic [AB_W-1:0]      ab_left;
    logic                 rb;
    logic                 tx;
    logic                 sel;
    logic                 ready;
    logic                 key_taken;
    logic                 reader_taken;
  } tpc_state_t;

  tpc_state_t        st;
  tpc_state_t        next_st;
  logic              brk_set;
  logic              load;
  logic [CODE_W-1:0] load_data;
  logic [AB_W-1:0]   ab_pos;

  // ----------------------------------------------------------------
  // Keyboard code former
  // ----------------------------------------------------------------
  tpc_char_if ch ();
  assign ch.key_code   = key_code_i;
  assign ch.shift      = shift_i;
  assign ch.ctrl       = ctrl_i;
  assign ch.parity_kbd = parity_kbd_i;

  tpc_encode u_encode (
    .ch (ch)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st              = st;
    next_st.key_taken    = 1'b0;
    next_st.reader_taken = 1'b0;
    brk_set              = 1'b0;
    load                 = 1'b0;
    load_data            = '0;
    ab_pos               = AB_W'(ANS_LEN) - st.ab_left;

    // Pins pass three stages; a lane rises once stages two and three both mark, falls as soon as they differ
    next_st.s1   = {break_release_button_i, copy_enable_i, line_connected_i, rx_line_i};
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.filt = (st.s2 & st.s3) | (st.filt & ~(st.s2 ^ st.s3));

    // Spacing run length; a bounded run ending on a live line is a break
    if (st.filt[SY_RX] == SPACE) begin
      if (st.space_cnt <= BRK_MAX) begin
        next_st.space_cnt = st.space_cnt + 1'b1;
      end
    end else begin
      next_st.space_cnt = '0;
      if (st.space_cnt >= BRK_MIN && st.space_cnt <= BRK_MAX && st.filt[SY_CONN]) begin
        brk_set = 1'b1;
      end
    end
    next_st.rb = brk_set | (st.rb & ~st.filt[SY_REL]);

    // Answer-back request queues the whole stored sequence
    if (ab_req_i && st.ab_left == '0 && !st.rb) begin
      next_st.ab_left = AB_W'(ANS_LEN);
    end

    case (st.state)
      TX_IDLE: begin
        next_st.tx = MARK;
        if (!st.rb) begin
          if (st.ab_left != '0) begin
            load            = 1'b1;
            load_data       = ANS_ROM[int'(ab_pos)*CODE_W +: CODE_W];
            next_st.ab_left = st.ab_left - 1'b1;
          end else if (st.ready && reader_req_i) begin
            load                 = 1'b1;
            load_data            = reader_holes_i;
            next_st.reader_taken = 1'b1;
          end else if (st.ready && key_req_i) begin
            load              = 1'b1;
            load_data         = ch.code8;
            next_st.key_taken = 1'b1;
          end
        end
        if (load) begin
          next_st.state     = TX_SEND;
          next_st.shreg     = {STOP_PAIR, load_data, SPACE};
          next_st.tx        = SPACE;
          next_st.bit_cnt   = '0;
          next_st.pulse_idx = '0;
        end
      end
      TX_SEND: begin
        if (st.rb) begin
          next_st.state = TX_IDLE;
          next_st.tx    = MARK;
        end else if (st.bit_cnt == PULSE_N - 1'b1) begin
          next_st.bit_cnt = '0;
          if (st.pulse_idx == IDX_W'(FRAME_LEN - 1)) begin
            next_st.state = TX_IDLE;
            next_st.tx    = MARK;
          end else begin
            next_st.pulse_idx = st.pulse_idx + 1'b1;
            next_st.shreg     = st.shreg >> 1;
            next_st.tx        = st.shreg[1];
          end
        end else begin
          next_st.bit_cnt = st.bit_cnt + 1'b1;
        end
      end
      default: begin
        next_st.state = TX_IDLE;
        next_st.tx    = MARK;
      end
    endcase

    // Receive selector: held marking without copy, series loop in half duplex
    if (!st.filt[SY_COPY]) begin
      next_st.sel = MARK;
    end else if (half_duplex_i) begin
      next_st.sel = st.filt[SY_RX] & st.tx;
    end else begin
      next_st.sel = st.filt[SY_RX];
    end

    next_st.ready = (next_st.state == TX_IDLE) && !next_st.rb && (next_st.ab_left == '0);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st      <= '0;
      st.s1   <= SYNC_RST;
      st.s2   <= SYNC_RST;
      st.s3   <= SYNC_RST;
      st.filt <= SYNC_RST;
      st.tx   <= MARK;
      st.sel  <= MARK;
    end else begin
      st <= next_st;
    end
  end

  assign tx_line_o             = st.tx;
  assign selector_o            = st.sel;
  assign receive_break_latch_o = st.rb;
  assign ready_o               = st.ready;
  assign key_taken_o           = st.key_taken;
  assign reader_taken_o        = st.reader_taken;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_copy_hold_mark: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !st.filt[SY_COPY] |=> selector_o)
    else $error("selector not held marking while copy disabled");

  a_break_blocks_tx: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    receive_break_latch_o |=> (tx_line_o && !key_taken_o && !reader_taken_o))
    else $error("transmission while receive break latch set");

  a_break_holds: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (receive_break_latch_o && !st.filt[SY_REL]) |=> receive_break_latch_o)
    else $error("receive break latch dropped without release");

  a_break_release: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(receive_break_latch_o) |-> $past(st.filt[SY_REL]))
    else $error("receive break latch cleared without release button");

  a_break_sets: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (st.filt[SY_RX] && st.space_cnt >= BRK_MIN && st.space_cnt <= BRK_MAX && st.filt[SY_CONN])
    |=> receive_break_latch_o)
    else $error("valid break interval did not set latch");

  a_idle_mark: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (st.state == TX_IDLE && !st.ready && st.ab_left == '0) |=> tx_line_o)
    else $error("send line not marking while idle");

  a_key_start: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (ready_o && key_req_i && !reader_req_i) |=> (!tx_line_o && key_taken_o && !ready_o))
    else $error("accepted key did not start with spacing pulse");

  a_pulse_steady: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (st.state == TX_SEND && !st.rb && st.bit_cnt != PULSE_N - 1'b1) |=> $stable(tx_line_o))
    else $error("send line changed inside a pulse");

  a_parity_even: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (parity_kbd_i && !(shift_i && ctrl_i)) |-> !(^ch.code8))
    else $error("parity keyboard code has odd mark count");

  a_nopar_p8: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !parity_kbd_i |-> ch.code8[CODE_W-1])
    else $error("nonparity pulse 8 not marking");

  a_shift_ctrl: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    shift_i |-> (ch.code8[P5_POS] != key_code_i[P5_POS]) && (!ctrl_i || !ch.code8[P7_POS]))
    else $error("shift or control modification wrong");

  a_both_p8: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (parity_kbd_i && shift_i && ctrl_i) |-> (ch.code8[CODE_W-1] == ^key_code_i))
    else $error("shift plus control altered pulse 8");

  a_break_no_ready: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    receive_break_latch_o |-> !ready_o)
    else $error("ready shown while receive break latch set");

  a_drop_no_break: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!st.filt[SY_CONN] && !receive_break_latch_o) |=> !receive_break_latch_o)
    else $error("break latched on a dropped line");

  a_start_space: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (st.state == TX_SEND && st.pulse_idx == '0) |-> !tx_line_o)
    else $error("start pulse not spacing");

  a_stop_mark: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (st.state == TX_SEND && st.pulse_idx >= IDX_W'(FRAME_LEN - 2)) |-> tx_line_o)
    else $error("stop pulse not marking");

  a_key_pulses: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (ch.code8[P5_POS-1:0] == key_code_i[P5_POS-1:0]) && (ch.code8[P7_POS-1] == key_code_i[P7_POS-1]))
    else $error("plain key pulses do not follow key code");

  a_noshift_p5: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !shift_i |-> (ch.code8[P5_POS] == key_code_i[P5_POS]))
    else $error("pulse 5 changed without shift");

  a_ctrl_p7: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ctrl_i |-> !ch.code8[P7_POS])
    else $error("control did not force pulse 7 spacing");

  a_half_own_copy: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (st.filt[SY_COPY] && half_duplex_i && !tx_line_o) |=> !selector_o)
    else $error("half duplex selector missed own spacing pulse");

endmodule

//--- tb/tpc_modem_model.sv
// Modem data set model: tones from the send loop, demodulated receive line
`timescale 1ns/1ns
module tpc_modem_model (
  // Clock
  input  wire logic sys_clk_i,
  // Line
  input  wire logic tx_line_i,
  output logic      rx_line_o,
  output logic      tone_mark_o
);
  assign tone_mark_o = tx_line_i;
  initial rx_line_o = 1'b1;
  // Timed spacing interval of n cycles, then marking again
  task automatic space_for(input int n);
    @(negedge sys_clk_i);
    rx_line_o = 1'b0;
    repeat (n) @(negedge sys_clk_i);
    rx_line_o = 1'b1;
  endtask
endmodule

//--- tb/test_teleprinter_code_and_break.sv
// Self-checking bench for the teleprinter line logic
`timescale 1ns/1ns
module test_teleprinter_code_and_break;
  import tpc_pkg::*;
  localparam int P = 4;
  logic              sys_clk_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              copy_en = 1'b1;
  logic              conn = 1'b1;
  logic              tone;
  logic              rel = 1'b0;
  logic              half = 1'b0;
  logic              par = 1'b0;
  logic              key_req = 1'b0;
  logic              shift = 1'b0;
  logic              ctrl = 1'b0;
  logic              rd_req = 1'b0;
  logic              ab_req = 1'b0;
  logic [KEY_W-1:0]  key_code = '0;
  logic [CODE_W-1:0] holes = '0;
  logic              rx, tx, sel, latch, ready, key_taken, rd_taken;
  int                mismatches = 0;
  int                tests_run = 0;
  int                cycles = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  tpc_line #(.PULSE_N(CNT_W'(P)), .BRK_MIN(CNT_W'(40)), .BRK_MAX(CNT_W'(80))) tpc_line_i (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .rx_line_i(rx), .line_connected_i(conn),
    .copy_enable_i(copy_en), .break_release_button_i(rel), .half_duplex_i(half),
    .parity_kbd_i(par), .key_req_i(key_req), .key_code_i(key_code), .shift_i(shift),
    .ctrl_i(ctrl), .reader_req_i(rd_req), .reader_holes_i(holes), .ab_req_i(ab_req),
    .tx_line_o(tx), .selector_o(sel), .receive_break_latch_o(latch), .ready_o(ready),
    .key_taken_o(key_taken), .reader_taken_o(rd_taken));

  tpc_modem_model tpc_modem_model_i (.sys_clk_i(sys_clk_i), .tx_line_i(tx), .rx_line_o(rx),
    .tone_mark_o(tone));

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Start pulse found, then every pulse checked at its middle
  task automatic check_frame(input logic [7:0] code);
    int n;
    n = 0;
    while (tx !== 1'b0 && n < 200) begin
      @(negedge sys_clk_i);
      n++;
    end
    repeat (P / 2) @(negedge sys_clk_i);
    check(tx, 8'h0, "start pulse");
    check(tone, 8'h0, "space tone");
    for (int k = 0; k < 10; k++) begin
      repeat (P) @(negedge sys_clk_i);
      check(tx, k < 8 ? code[k] : 1'b1, "code pulse");
      if (half) check(sel, tx, "own copy");
    end
  endtask

  // Source 0 is the keyboard, 1 the tape reader
  task automatic request(input int src, input logic [7:0] code);
    int n;
    n = 0;
    key_req = (src == 0);
    rd_req = (src == 1);
    while ((src == 0 ? key_taken : rd_taken) !== 1'b1 && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    key_req = 1'b0;
    rd_req = 1'b0;
    check(n < 300, 8'h1, "request taken");
    check_frame(code);
  endtask

  task automatic send_key(input logic [6:0] k, input logic s, input logic c);
    logic [6:0] m;
    logic       p8;
    m = k;
    m[4] = m[4] ^ s;
    if (c) m[6] = 1'b0;
    p8 = !par ? 1'b1 : (s && c) ? ^k : ^m;
    key_code = k;
    shift = s;
    ctrl = c;
    request(0, {p8, m});
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    repeat (10) @(negedge sys_clk_i);
    check({tx, sel, latch}, 8'h6, "reset state");
    reset_n_i = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        par = p[0];
        send_key(7'h43, m[0], m[1]);
        send_key(7'h3c, m[0], m[1]);
      end
    end
    holes = 8'ha5;
    request(1, 8'ha5);
    holes = 8'h00;
    request(1, 8'h00);
    ab_req = 1'b1;
    @(negedge sys_clk_i);
    ab_req = 1'b0;
    for (int i = 0; i < ANS_LEN_DEF; i++) check_frame(ANS_ROM_DEF[i*8 +: 8]);
    half = 1'b1;
    send_key(7'h55, 1'b0, 1'b0);
    half = 1'b0;
    copy_en = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    fork
      tpc_modem_model_i.space_for(20);
      begin
        repeat (12) @(negedge sys_clk_i);
        check(sel, 8'h1, "selector held");
      end
    join
    copy_en = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    fork
      tpc_modem_model_i.space_for(20);
      begin
        repeat (12) @(negedge sys_clk_i);
        check(sel, 8'h0, "selector copies");
      end
    join
    tpc_modem_model_i.space_for(100);
    repeat (8) @(negedge sys_clk_i);
    check(latch, 8'h0, "disconnect ignored");
    conn = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    tpc_modem_model_i.space_for(50);
    repeat (8) @(negedge sys_clk_i);
    check(latch, 8'h0, "dropped line ignored");
    conn = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    tpc_modem_model_i.space_for(50);
    repeat (8) @(negedge sys_clk_i);
    check({latch, ready}, 8'h2, "break latched");
    key_code = 7'h41;
    key_req = 1'b1;
    repeat (30) begin
      @(negedge sys_clk_i);
      check(tx, 8'h1, "send blocked");
    end
    rel = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    check(latch, 8'h0, "break released");
    rel = 1'b0;
    send_key(7'h41, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule
